// [rtl/nvc_core.sv]
/*
 * Core-side end: APB slave whose writes become register and table accesses
 * on the link. Assumes a single APB master; two-cycle access phase, pready after one wait state.
 */
`timescale 1ns/1ps
`default_nettype none
module nvc_core
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link
    nvc_if.core link
);
    // ****************************************
    // Own map: 0x00 reg addr/data, 0x04 table op, 0x08 result, 0x0C status, 0x10 table address
    // ****************************************
    localparam logic [7:0] CMD_REG = 8'h00;
    localparam logic [7:0] CMD_TBL = 8'h04;
    localparam logic [7:0] RES_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;
    localparam logic [7:0] TADDR_OFS = 8'h10;

    logic access;
    logic [23:0] taddr;
    logic [1:0] phase;
    assign access = psel && penable;
    assign pready = phase == 2'd1;
    assign pslverr = 1'b0;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            phase <= 2'd0;
        else if (access && phase == 2'd0)
            phase <= 2'd1;
        else
            phase <= 2'd0;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            link.reg_write <= 1'b0;
            link.reg_read <= 1'b0;
            link.reg_addr <= 16'h0000;
            link.reg_wdata <= 16'h0000;
            link.tbl_op <= nvc_pkg::TBL_NONE;
            link.tbl_addr <= 24'h000000;
            link.tbl_wdata <= 16'h0000;
            link.watchdog_reset <= 1'b0;
            taddr <= 24'h000000;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            link.reg_write <= 1'b0;
            link.reg_read <= 1'b0;
            link.tbl_op <= nvc_pkg::TBL_NONE;
            if (access && phase == 2'd0)
            begin
                if (pwrite && paddr[7:0] == CMD_REG)
                begin
                    // Bit 31 selects write; sequencing and spacing are software's job
                    link.reg_write <= pwdata[31];
                    link.reg_read <= !pwdata[31];
                    link.reg_addr <= {1'b0, pwdata[30:16]};
                    link.reg_wdata <= pwdata[15:0];
                end
                else if (pwrite && paddr[7:0] == TADDR_OFS)
                    taddr <= pwdata[23:0];
                else if (pwrite && paddr[7:0] == CMD_TBL)
                begin
                    link.tbl_op <= pwdata[31] ? nvc_pkg::TBL_WRITE : nvc_pkg::TBL_READ;
                    link.tbl_addr <= taddr;
                    link.tbl_wdata <= pwdata[15:0];
                    link.watchdog_reset <= pwdata[30];
                end
                else if (!pwrite && paddr[7:0] == RES_OFS)
                    prdata <= {link.tbl_rdata, link.reg_rdata};
                else if (!pwrite && paddr[7:0] == STAT_OFS)
                    prdata <= {30'h0, link.busy, link.done_flag};
                else
                    prdata <= 32'h0000_0000;
            end
        end
    end
endmodule : nvc_core
`default_nettype wire

// [rtl/nvc_device.sv]
/*
 * Nonvolatile memory controller: unlock keys, control register, address
 * capture, data EEPROM word/block erase and program with timed cycle.
 * Assumes the core side keeps one register or table access per cycle.
 */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module nvc_device #(
    parameter int WRITE_CYCLES = nvc_pkg::WRITE_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Core link
    nvc_if.device link,
    // User side
    output logic error_flag,
    output logic busy_out
);
    typedef enum logic [1:0]
    {
        UNLOCK_IDLE = 2'b00,
        UNLOCK_HALF = 2'b01,
        UNLOCK_OPEN = 2'b10
    } nvc_unlock_e;

    logic [15:0] memory [0:nvc_pkg::EE_WORDS-1];
    logic [15:0] latches [0:nvc_pkg::EE_BLOCK_WORDS-1];
    logic [15:0] address_low;
    logic [7:0] address_upper;
    logic start_bit;
    logic write_enable_bit;
    logic error_bit;
    logic write_interrupt_bit;
    logic [6:0] op_select;
    logic [6:0] op_latched;
    logic [11:0] op_index;
    logic done_flag;
    logic [31:0] cycle_count;
    logic [15:0] read_data;
    logic [15:0] table_data;
    nvc_unlock_e unlock;
    logic wr_ctrl;
    logic start_req;
    logic finish;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [11:0] ee_index(input logic [23:0] a);
        ee_index = a[12:1];
    endfunction : ee_index

    function automatic logic in_window(input logic [23:0] a);
        in_window = (a >= nvc_pkg::EE_BASE) && (a <= nvc_pkg::EE_LAST);
    endfunction : in_window

    assign wr_ctrl = link.reg_write && (link.reg_addr == nvc_pkg::CONTROL_OFS);
    // Enable must already be set; a same-write enable does not count
    assign start_req = wr_ctrl && link.reg_wdata[nvc_pkg::START_POS] && write_enable_bit
        && (unlock == UNLOCK_OPEN) && !start_bit;
    assign finish = start_bit && (cycle_count == 32'(WRITE_CYCLES - 1));

    // ****************************************
    // Unlock sequence
    // ****************************************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            unlock <= UNLOCK_IDLE;
        else if (link.reg_write)
        begin
            unique case (unlock)
                UNLOCK_IDLE:
                    unlock <= (link.reg_addr == nvc_pkg::UNLOCK_KEY_OFS &&
                        link.reg_wdata[7:0] == nvc_pkg::KEY_FIRST) ? UNLOCK_HALF : UNLOCK_IDLE;
                UNLOCK_HALF:
                    unlock <= (link.reg_addr == nvc_pkg::UNLOCK_KEY_OFS &&
                        link.reg_wdata[7:0] == nvc_pkg::KEY_SECOND) ? UNLOCK_OPEN : UNLOCK_IDLE;
                UNLOCK_OPEN:
                    unlock <= UNLOCK_IDLE;
                default:
                    unlock <= UNLOCK_IDLE;
            endcase
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            write_enable_bit <= 1'b0;
            write_interrupt_bit <= 1'b0;
            op_select <= 7'h00;
        end
        else if (wr_ctrl)
        begin
            // Only software touches the enable; it never gates a running cycle
            write_enable_bit <= link.reg_wdata[nvc_pkg::WRITE_ENABLE_POS];
            write_interrupt_bit <= link.reg_wdata[nvc_pkg::WRITE_INTERRUPT_POS];
            op_select <= link.reg_wdata[nvc_pkg::OPSEL_LSB +: nvc_pkg::OPSEL_W];
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            start_bit <= 1'b0;
        else if (finish)
            start_bit <= 1'b0;
        else if (link.watchdog_reset)
            start_bit <= 1'b0;
        else if (start_req)
            start_bit <= 1'b1;
    end

    // Watchdog cause mid-cycle ends it; error marks the lost write
    logic interrupted;
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            interrupted <= 1'b0;
        else
            interrupted <= start_bit && link.watchdog_reset;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            error_bit <= 1'b0;
        else if (interrupted)
            error_bit <= 1'b1;
        else if (wr_ctrl)
            error_bit <= link.reg_wdata[nvc_pkg::WRITE_ERROR_POS];
    end

    // ****************************************
    // Address capture and cycle
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (link.tbl_op != nvc_pkg::TBL_NONE && !start_bit)
        begin
            address_low <= link.tbl_addr[15:0];
            address_upper <= link.tbl_addr[23:16];
        end
        else if (link.reg_write && link.reg_addr == nvc_pkg::ADDR_LOW_OFS && !start_bit)
            address_low <= link.reg_wdata;
        else if (link.reg_write && link.reg_addr == nvc_pkg::ADDR_UPPER_OFS && !start_bit)
            address_upper <= link.reg_wdata[7:0];
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cycle_count <= 32'h0000_0000;
            op_latched <= 7'h00;
            op_index <= 12'h000;
        end
        else if (start_req)
        begin
            cycle_count <= 32'h0000_0000;
            op_latched <= op_select;
            op_index <= ee_index({address_upper, address_low});
        end
        else if (start_bit && !link.watchdog_reset)
            cycle_count <= cycle_count + 32'h0000_0001;
    end

    always_ff @(posedge clock)
    begin
        if (link.tbl_op == nvc_pkg::TBL_WRITE && in_window(link.tbl_addr))
            latches[link.tbl_addr[4:1]] <= link.tbl_wdata;
        if (finish && in_window({address_upper, address_low}))
        begin
            for (int i = 0; i < nvc_pkg::EE_BLOCK_WORDS; i++)
            begin
                if (op_latched == nvc_pkg::OP_EE_BLOCK_ERASE)
                    memory[{op_index[11:4], 4'(i)}] <= 16'hFFFF;
                else if (op_latched == nvc_pkg::OP_EE_BLOCK_PROG)
                    memory[{op_index[11:4], 4'(i)}] <= latches[i];
            end
            if (op_latched == nvc_pkg::OP_EE_WORD_ERASE)
                memory[op_index] <= 16'hFFFF;
            else if (op_latched == nvc_pkg::OP_EE_WORD_PROG)
                memory[op_index] <= latches[op_index[3:0]];
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            done_flag <= 1'b0;
        else if (finish)
            done_flag <= 1'b1;
        else if (wr_ctrl && !link.reg_wdata[nvc_pkg::WRITE_INTERRUPT_POS] && write_interrupt_bit)
            done_flag <= 1'b0;
    end

    // ****************************************
    // Read paths
    // ****************************************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_data <= 16'h0000;
            table_data <= 16'h0000;
        end
        else
        begin
            unique case (link.reg_addr)
                nvc_pkg::CONTROL_OFS:
                    read_data <= {start_bit, write_enable_bit, error_bit, 4'h0, write_interrupt_bit, 1'b0, op_select};
                nvc_pkg::ADDR_LOW_OFS:
                    read_data <= address_low;
                nvc_pkg::ADDR_UPPER_OFS:
                    read_data <= {8'h00, address_upper};
                default:
                    read_data <= 16'h0000;
            endcase
            // Busy array reads give a fixed filler value
            if (link.tbl_op == nvc_pkg::TBL_READ)
                table_data <= start_bit ? 16'hDEAD : memory[ee_index(link.tbl_addr)];
        end
    end

    assign link.reg_rdata = read_data;
    assign link.tbl_rdata = table_data;
    assign link.done_flag = done_flag;
    assign link.busy = start_bit;
    assign error_flag = error_bit;
    assign busy_out = start_bit;
endmodule : nvc_device
`default_nettype wire

// [rtl/nvc_if.sv]
/*
 * Link between the core side (APB-driven master) and the controller.
 * Assumes both ends share clock and reset.
 */
`timescale 1ns/1ps
`default_nettype none
interface nvc_if;
    // Register access
    logic reg_write;
    logic reg_read;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    // Table access
    nvc_pkg::nvc_tbl_e tbl_op;
    logic [23:0] tbl_addr;
    logic [15:0] tbl_wdata;
    logic [15:0] tbl_rdata;
    // Reset cause
    logic watchdog_reset;
    // Status
    logic done_flag;
    logic busy;

    modport device
    (
        input reg_write, reg_read, reg_addr, reg_wdata, tbl_op, tbl_addr, tbl_wdata, watchdog_reset,
        output reg_rdata, tbl_rdata, done_flag, busy
    );
    modport core
    (
        output reg_write, reg_read, reg_addr, reg_wdata, tbl_op, tbl_addr, tbl_wdata, watchdog_reset,
        input reg_rdata, tbl_rdata, done_flag, busy
    );
endinterface : nvc_if
`default_nettype wire

// [rtl/nvc_pkg.sv]
/*
 * Shared constants for the nonvolatile memory controller and its core-side
 * register master: offsets, control fields, keys, reset values, timing.
 * Assumes a single 10 MHz clock in both ends.
 */
`default_nettype none
package nvc_pkg;
    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [15:0] ADDR_LOW_OFS = 16'h0762;
    localparam logic [15:0] ADDR_UPPER_OFS = 16'h0764;
    localparam logic [15:0] UNLOCK_KEY_OFS = 16'h0766;
    localparam logic [15:0] CONTROL_OFS = 16'h0970;
    // ****************************************
    // Control register fields
    // ****************************************
    localparam int START_POS = 15;
    localparam int WRITE_ENABLE_POS = 14;
    localparam int WRITE_ERROR_POS = 13;
    localparam int WRITE_INTERRUPT_POS = 8;
    localparam int OPSEL_LSB = 0;
    localparam int OPSEL_W = 7;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_WMASK = 16'h417F;
    // Operation select codes
    localparam logic [6:0] OP_EE_WORD_ERASE = 7'h44;
    localparam logic [6:0] OP_EE_BLOCK_ERASE = 7'h45;
    localparam logic [6:0] OP_EE_WORD_PROG = 7'h04;
    localparam logic [6:0] OP_EE_BLOCK_PROG = 7'h0A;
    // ****************************************
    // Unlock keys
    // ****************************************
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // ****************************************
    // EEPROM window
    // ****************************************
    localparam logic [23:0] EE_BASE = 24'h7FF000;
    localparam logic [23:0] EE_LAST = 24'h7FFFFE;
    localparam int EE_WORDS = 4096;
    localparam int EE_BLOCK_WORDS = 16;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_HZ = 10_000_000;
    localparam int WRITE_TIME_US = 2000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * (CLOCK_HZ / 1_000_000);
    // Table operation kinds from the core
    typedef enum logic [1:0]
    {
        TBL_NONE = 2'b00,
        TBL_READ = 2'b01,
        TBL_WRITE = 2'b10
    } nvc_tbl_e;
endpackage : nvc_pkg
`default_nettype wire

// [tb/nvc_link_monitor.sv]
/* Link checker: start, timing, done and abort relations.
   Assumes one clock and reset_n async low. */
`timescale 1ns/1ps
`default_nettype none
module nvc_link_monitor #(
    parameter int WRITE_CYCLES = nvc_pkg::WRITE_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Link
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire nvc_pkg::nvc_tbl_e tbl_op,
    input wire logic [15:0] tbl_rdata,
    input wire logic watchdog_reset,
    input wire logic done_flag,
    input wire logic busy
);
    localparam logic [15:0] CTL = nvc_pkg::CONTROL_OFS;
    localparam logic [15:0] KEY = nvc_pkg::UNLOCK_KEY_OFS;
    logic [31:0] w1, w2, w3, run_cnt;
    logic enable_seen;
    logic ctl_wr;
    assign ctl_wr = reg_write && reg_addr == CTL;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ****************************************
    // Helpers: last three writes, enable, run length
    // ****************************************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            {w1, w2, w3} <= '0;
        else if (reg_write)
            {w1, w2, w3} <= {reg_addr, reg_wdata, w1, w2};
    end
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            enable_seen <= 1'b0;
        else if (ctl_wr)
            enable_seen <= reg_wdata[nvc_pkg::WRITE_ENABLE_POS];
    end
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            run_cnt <= '0;
        else
            run_cnt <= busy ? run_cnt + 32'h1 : 32'h0;
    end
    // ****************************************
    // Properties
    // ****************************************
    property p_start_write;
        $rose(busy) |-> $past(ctl_wr) && w1[31:16] == CTL && w1[15];
    endproperty
    a_start_write: assert property (p_start_write) else $error("busy without start write");
    property p_start_keys;
        $rose(busy) |-> w2 == {KEY, 8'h00, nvc_pkg::KEY_SECOND} && w3 == {KEY, 8'h00, nvc_pkg::KEY_FIRST};
    endproperty
    a_start_keys: assert property (p_start_keys) else $error("busy without key pair");
    property p_start_write_enable_bit;
        $rose(busy) |-> $past(enable_seen);
    endproperty
    a_start_write_enable_bit: assert property (p_start_write_enable_bit) else $error("busy without earlier enable");
    property p_length;
        $fell(busy) && !watchdog_reset && !$past(watchdog_reset) |-> run_cnt == WRITE_CYCLES;
    endproperty
    a_length: assert property (p_length) else $error("cycle length wrong");
    property p_done_set;
        $fell(busy) && !$past(watchdog_reset) |-> ##[0:1] done_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set at end");
    property p_done_hold;
        done_flag && !ctl_wr && !watchdog_reset |=> done_flag;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done cleared by itself");
    property p_keep_run;
        busy && ctl_wr && !reg_wdata[14] && !watchdog_reset && run_cnt < WRITE_CYCLES - 2 |=> busy;
    endproperty
    a_keep_run: assert property (p_keep_run) else $error("cycle stopped by write");
    property p_read_busy;
        busy && tbl_op == nvc_pkg::TBL_READ && !watchdog_reset |=> tbl_rdata == 16'hDEAD;
    endproperty
    a_read_busy: assert property (p_read_busy) else $error("read in cycle not marked");
    property p_abort;
        busy && watchdog_reset |=> !busy;
    endproperty
    a_abort: assert property (p_abort) else $error("cycle not halted");
    property p_key_wo;
        reg_read && reg_addr == KEY |=> reg_rdata == 16'h0000;
    endproperty
    a_key_wo: assert property (p_key_wo) else $error("key register readable");
    c_start: cover property ($rose(busy));
    c_done: cover property ($rose(done_flag));
    c_abort: cover property (busy && watchdog_reset);
endmodule : nvc_link_monitor
`default_nettype wire

// [tb/test_nvm_unlock_and_eeprom_control.sv]
/* Bench: APB master into the core end, core and controller joined.
   Assumes the controller built with a short cycle count. */
`timescale 1ns/1ps
`default_nettype none
module test_nvm_unlock_and_eeprom_control;
    // Long enough for a read and a write inside one cycle
    localparam int W = 60;
    localparam logic [15:0] CTL = nvc_pkg::CONTROL_OFS;
    localparam logic [15:0] ADL = nvc_pkg::ADDR_LOW_OFS;
    logic clock, reset_n, psel, penable, pwrite, pready, pslverr, error_flag, busy_out;
    logic [31:0] paddr, pwdata, prdata, rd;
    int errors = 0;
    int check_count = 0;
    nvc_if link();
    nvc_core u_nvc_core (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    nvc_device #(.WRITE_CYCLES(W)) u_nvc_device (.clock(clock), .reset_n(reset_n), .link(link),
        .error_flag(error_flag), .busy_out(busy_out));
    nvc_link_monitor #(.WRITE_CYCLES(W)) u_nvc_link_monitor (.clock(clock), .reset_n(reset_n),
        .reg_write(link.reg_write), .reg_read(link.reg_read), .reg_addr(link.reg_addr),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .tbl_op(link.tbl_op),
        .tbl_rdata(link.tbl_rdata), .watchdog_reset(link.watchdog_reset), .done_flag(link.done_flag),
        .busy(link.busy));
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task wrap_up();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task reg_wr(input logic [15:0] ofs, input logic [15:0] d);
        apb(1'b1, 32'h0, {1'b1, ofs[14:0], d});
    endtask : reg_wr
    task reg_rd(input logic [15:0] ofs);
        apb(1'b1, 32'h0, {1'b0, ofs[14:0], 16'h0000});
        apb(1'b0, 32'h8, 32'h0);
    endtask : reg_rd
    task tbl_wr(input logic [23:0] a, input logic [15:0] d);
        apb(1'b1, 32'h10, {8'h00, a});
        apb(1'b1, 32'h4, {16'h8000, d});
    endtask : tbl_wr
    task tbl_rd(input logic [23:0] a);
        apb(1'b1, 32'h10, {8'h00, a});
        apb(1'b1, 32'h4, 32'h0);
        apb(1'b0, 32'h8, 32'h0);
    endtask : tbl_rd
    // Keys back to back, nothing else between them
    task start_op(input logic [6:0] op);
        reg_wr(CTL, {9'h080, op});
        reg_wr(nvc_pkg::UNLOCK_KEY_OFS, {8'h00, nvc_pkg::KEY_FIRST});
        reg_wr(nvc_pkg::UNLOCK_KEY_OFS, {8'h00, nvc_pkg::KEY_SECOND});
        reg_wr(CTL, {9'h180, op});
    endtask : start_op
    task run_check(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (6)
        begin
            @(posedge clock);
            if (busy_out === 1'b1)
                seen = 1'b1;
        end
        check("started", seen, exp);
    endtask : run_check
    task wait_idle();
        int n;
        n = 0;
        while (busy_out === 1'b1 && n < 4 * W)
        begin
            @(posedge clock);
            n++;
        end
        check("cycle_end", n < 4 * W, 1);
    endtask : wait_idle
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset();
        reg_rd(CTL);
        check("ctl_reset", rd[15:0], nvc_pkg::CONTROL_RESET);
        reg_rd(nvc_pkg::UNLOCK_KEY_OFS);
        check("key_read", rd[15:0], 16'h0000);
        check("pslverr", pslverr, 1'b0);
        check("done_reset", link.done_flag, 1'b0);
    endtask : t_reset
    task t_refuse();
        reg_wr(CTL, 16'h4044);
        reg_wr(CTL, 16'hC044);
        run_check(1'b0);
        reg_wr(CTL, 16'h0044);
        reg_wr(nvc_pkg::UNLOCK_KEY_OFS, 16'h0055);
        reg_wr(nvc_pkg::UNLOCK_KEY_OFS, 16'h00AA);
        reg_wr(CTL, 16'hC044);
        run_check(1'b0);
        reg_wr(CTL, 16'h4044);
        reg_wr(nvc_pkg::UNLOCK_KEY_OFS, 16'h0055);
        reg_wr(ADL, 16'hF010);
        reg_wr(nvc_pkg::UNLOCK_KEY_OFS, 16'h00AA);
        reg_wr(CTL, 16'hC044);
        run_check(1'b0);
    endtask : t_refuse
    task t_erase();
        tbl_wr(24'h7FF010, 16'h1234);
        start_op(nvc_pkg::OP_EE_WORD_ERASE);
        run_check(1'b1);
        tbl_rd(24'h7FF010);
        check("read_busy", rd[31:16], 16'hDEAD);
        reg_wr(CTL, 16'h0044);
        // The write landed at the edge that ended the transfer; look one edge later
        @(posedge clock);
        check("still_busy", busy_out, 1'b1);
        wait_idle();
        check("done_set", link.done_flag, 1'b1);
        apb(1'b0, 32'hC, 32'h0);
        check("status", rd[1:0], 2'b01);
        reg_rd(CTL);
        check("start_clear", rd[15:14], 2'b00);
        tbl_rd(24'h7FF010);
        check("erased", rd[31:16], 16'hFFFF);
        reg_rd(ADL);
        check("addr_low", rd[15:0], 16'hF010);
        reg_rd(nvc_pkg::ADDR_UPPER_OFS);
        check("addr_up", rd[7:0], 8'h7F);
        reg_wr(CTL, 16'h0144);
        reg_wr(CTL, 16'h0044);
        @(posedge clock);
        check("done_clear", link.done_flag, 1'b0);
    endtask : t_erase
    task t_prog();
        tbl_wr(24'h7FF010, 16'h1234);
        start_op(nvc_pkg::OP_EE_WORD_PROG);
        run_check(1'b1);
        wait_idle();
        tbl_rd(24'h7FF010);
        check("programmed", rd[31:16], 16'h1234);
        reg_rd(CTL);
        check("enable_kept", rd[15:14], 2'b01);
        reg_wr(ADL, 16'hF01E);
        start_op(nvc_pkg::OP_EE_BLOCK_ERASE);
        run_check(1'b1);
        wait_idle();
        tbl_rd(24'h7FF010);
        check("block_erased", rd[31:16], 16'hFFFF);
    endtask : t_prog
    task t_abort();
        tbl_wr(24'h7FF040, 16'h5555);
        start_op(nvc_pkg::OP_EE_BLOCK_PROG);
        run_check(1'b1);
        apb(1'b1, 32'h4, 32'h4000_0000);
        repeat (2)
            @(posedge clock);
        check("error_flag", error_flag, 1'b1);
        check("halted", busy_out, 1'b0);
        apb(1'b1, 32'h4, 32'h0);
        reg_rd(CTL);
        check("write_error_flag_bit", rd[13], 1'b1);
        reg_rd(ADL);
        check("addr_kept", rd[15:0], 16'hF040);
    endtask : t_abort
    initial
    begin
        clock = 1'b0;
        forever
            #50 clock = ~clock;
    end
    initial
    begin
        #3_000_000;
        errors++;
        wrap_up();
    end
    initial
    begin
        {reset_n, psel, penable, pwrite} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (16)
            @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_refuse();
        t_erase();
        t_prog();
        t_abort();
        wrap_up();
    end
endmodule : test_nvm_unlock_and_eeprom_control
`default_nettype wire
